// file: cmic_cpu_model.sv
// Purpose: sequencer stand-in that issues instruction strobes to the controller
// Assumes: an instruction lasts 3 cycles, or 6 when slow_in is high
// Notes:   a halt command is issued at the next S2 (phase 1), in the same instruction when it arrives at phase 0
`timescale 1ns/1ps
module cmic_cpu_model (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic cpu_run_in,
  input  wire logic pc_load_in,
  input  wire logic halt_cmd_in,
  input  wire logic slow_in,
  output logic      halt_instr_out,
  output logic      instr_done_out
);
  // ****************************************
  // Instruction phase counter
  // ****************************************
  logic [2:0] ph_q;
  logic       pend_q;
  logic [2:0] last_ph;
  assign last_ph = slow_in ? 3'h5 : 3'h2;
  // Strobes only while allowed to run, so a frozen core never advances
  assign instr_done_out = cpu_run_in & (ph_q == last_ph);
  assign halt_instr_out = cpu_run_in & pend_q & (ph_q == 3'h1);
  always_ff @(posedge mclk_in) begin
    if (rst_in | ~cpu_run_in | pc_load_in | instr_done_out) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
    if (rst_in | halt_instr_out) begin
      pend_q <= 1'b0;
    end else if (halt_cmd_in) begin
      pend_q <= 1'b1;
    end
  end
endmodule // cmic_cpu_model

// file: cmic_ctrl.sv
// Purpose: operating state control (reset, run, halt) and vectored
//          interrupt acceptance for the 4-bit core
// Assumes: instr_done_in pulses at each instruction boundary, halt_instr_in
//          pulses at S2 of a halt instruction, requests are held by their
//          owners until irq_ack_out
// Notes:   data RAM and LCD segment storage have no reset path here
`timescale 1ns/1ps
`include "cmic_defs.svh"
module cmic_ctrl #(
  parameter int P2K_CYC = `CMIC_CLK_HZ / `CMIC_PIN_SMP_HZ,
  parameter int P1HZ_CYC = `CMIC_CLK_HZ / `CMIC_KEY_SMP_HZ
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire logic                  reset_pin_in,
  input  wire logic                  lfclk_stop_in,
  input  wire logic                  stop_det_opt_in,
  input  wire logic [3:0]            key_port_in,
  input  wire logic [1:0]            key_width_opt_in,
  input  wire logic                  halt_instr_in,
  input  wire logic                  instr_done_in,
  input  wire logic                  return_from_irq_instr_in,
  input  wire logic                  ei_in,
  input  wire logic                  di_in,
  input  wire logic                  melody_data_req_in,
  input  wire logic [`CMIC_NSRC-1:0] irq_req_in,
  input  wire logic [`CMIC_NSRC-1:0] irq_en_in,
  input  wire logic [15:0]           ret_pc_in,
  output logic                       sys_reset_out,
  output logic                       lcd_off_out,
  output logic                       bias_on_out,
  output logic                       cpu_run_out,
  output logic                       halt_state_flag_out,
  output logic                       master_irq_enable_out,
  output logic                       pc_load_out,
  output logic [15:0]                pc_value_out,
  output logic                       push_pc_out,
  output logic [15:0]                push_data_out,
  output logic [`CMIC_NSRC-1:0]      irq_ack_out,
  output logic                       melody_xfer_out
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [5:0] meta_q;
  logic [5:0] sync_q;

  always_ff @(posedge mclk_in) begin
    meta_q <= {lfclk_stop_in, reset_pin_in, key_port_in};
    sync_q <= meta_q;
  end

  wire [3:0] key_s_w  = sync_q[3:0];
  wire       pin_s_w  = sync_q[4];
  wire       stop_s_w = sync_q[5];

  // ****************************************************************
  // Sampling dividers
  // ****************************************************************
  // The time base keeps ticking in every state, halt included
  logic [16:0] p2k_cnt_q;
  logic [27:0] p1_cnt_q;

  wire p2k_tick_w = (p2k_cnt_q == 17'(P2K_CYC - 1)); // RULE12
  wire key_tick_w = (p1_cnt_q == 28'(P1HZ_CYC - 1)); // RULE12

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      p2k_cnt_q <= 17'h00000;
      p1_cnt_q  <= 28'h0000000;
    end else begin
      p2k_cnt_q <= p2k_tick_w ? 17'h00000 : p2k_cnt_q + 17'h00001;
      p1_cnt_q  <= key_tick_w ? 28'h0000000 : p1_cnt_q + 28'h0000001;
    end
  end

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // A single high sample is enough, so a 1 ms pulse is always seen
  logic       pin_hi_q;
  logic [1:0] key_cnt_q;
  logic       key_rst_q;

  wire [3:0] key_mask_w = (key_width_opt_in == `CMIC_KEY_W2) ? `CMIC_KEY_MASK2 :
                          (key_width_opt_in == `CMIC_KEY_W3) ? `CMIC_KEY_MASK3 :
                                                               `CMIC_KEY_MASK4; // RULE6
  wire [3:0] key_sel_w  = key_s_w & key_mask_w;
  wire key_match_w = (key_sel_w == key_mask_w) | (key_sel_w == `CMIC_KEY_NONE); // RULE5
  wire stop_act_w  = stop_s_w & stop_det_opt_in; // RULE4
  wire rst_src_w   = pin_hi_q | key_rst_q | stop_act_w; // RULE16

  wire [1:0] key_cnt_d = !key_match_w ? 2'h0 :
                         (key_cnt_q == `CMIC_KEY_CNT_HIT) ? key_cnt_q : key_cnt_q + 2'h1;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_hi_q  <= 1'b0;
      key_cnt_q <= 2'h0;
      key_rst_q <= 1'b0;
    end else begin
      if (p2k_tick_w)
        pin_hi_q <= pin_s_w; // RULE3
      if (key_tick_w) begin
        key_cnt_q <= key_cnt_d;
        key_rst_q <= key_match_w & (key_cnt_q != 2'h0); // RULE7
      end
    end
  end

  // ****************************************************************
  // Priority encoder
  // ****************************************************************
  cmic_if pif ();
  assign pif.req = irq_req_in; // RULE18
  assign pif.en  = irq_en_in;
  assign pif.master_irq_enable = master_irq_enable_out;

  cmic_prio u_prio (
    .bus (pif)
  );

  // ****************************************************************
  // Operating state machine
  // ****************************************************************
  cmic_pkg::cmic_state_t st_q;
  cmic_pkg::cmic_state_t st_d;
  logic                  mel_pend_q;

  wire take_w = instr_done_in & pif.accept &
                ((st_q == cmic_pkg::CMIC_ST_RUN) | (st_q == cmic_pkg::CMIC_ST_WAKE)); // RULE14
  wire halt_go_w = halt_instr_in & (st_q == cmic_pkg::CMIC_ST_RUN) & !pif.accept; // RULE11 RULE13
  wire mel_done_w = (st_q == cmic_pkg::CMIC_ST_MXFER);

  always_comb begin
    st_d = st_q;
    case (st_q)
      cmic_pkg::CMIC_ST_RESET: begin
        if (!rst_src_w)
          st_d = cmic_pkg::CMIC_ST_RUN;
      end
      cmic_pkg::CMIC_ST_RUN: begin
        if (halt_go_w)
          st_d = cmic_pkg::CMIC_ST_HALT;
      end
      cmic_pkg::CMIC_ST_HALT: begin
        if (pif.wake)
          st_d = cmic_pkg::CMIC_ST_WAKE; // RULE15
        else if (mel_pend_q)
          st_d = cmic_pkg::CMIC_ST_MEL; // RULE17
      end
      cmic_pkg::CMIC_ST_WAKE: begin
        if (instr_done_in)
          st_d = cmic_pkg::CMIC_ST_RUN; // RULE14
      end
      cmic_pkg::CMIC_ST_MEL: begin
        if (instr_done_in)
          st_d = cmic_pkg::CMIC_ST_MXFER;
      end
      cmic_pkg::CMIC_ST_MXFER: begin
        st_d = cmic_pkg::CMIC_ST_HALT; // RULE17
      end
      default: begin
        st_d = cmic_pkg::CMIC_ST_RESET;
      end
    endcase
    // Reset wins over every state and aborts whatever runs
    if (rst_src_w)
      st_d = cmic_pkg::CMIC_ST_RESET; // RULE10 RULE16
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in)
      st_q <= cmic_pkg::CMIC_ST_RESET;
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // Melody request latch and master enable
  // ****************************************************************
  // In run mode the transfer rides on the next instruction boundary
  wire mel_run_w = mel_pend_q & instr_done_in & (st_q == cmic_pkg::CMIC_ST_RUN);
  wire mel_clr_w = mel_run_w | mel_done_w;
  // Set wins over clear for both flags
  wire mel_pend_d = melody_data_req_in | (mel_pend_q & !mel_clr_w);
  wire master_set_w        = return_from_irq_instr_in | ei_in; // RULE23
  wire master_irq_enable_d = master_set_w | (master_irq_enable_out & !take_w & !di_in); // RULE23

  always_ff @(posedge mclk_in) begin
    if (rst_in | rst_src_w) begin
      mel_pend_q            <= 1'b0;
      master_irq_enable_out <= 1'b0; // RULE23
    end else begin
      mel_pend_q            <= mel_pend_d;
      master_irq_enable_out <= master_irq_enable_d;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  wire rst_d_w   = (st_d == cmic_pkg::CMIC_ST_RESET);
  wire halt_d_w  = (st_d == cmic_pkg::CMIC_ST_HALT) | (st_d == cmic_pkg::CMIC_ST_MEL) |
                   (st_d == cmic_pkg::CMIC_ST_MXFER);
  wire run_d_w   = (st_d == cmic_pkg::CMIC_ST_RUN) | (st_d == cmic_pkg::CMIC_ST_WAKE) |
                   (st_d == cmic_pkg::CMIC_ST_MEL);
  wire boot_w    = (st_q == cmic_pkg::CMIC_ST_RESET) & !rst_src_w;
  wire pc_load_d = boot_w | (take_w & !rst_src_w);
  wire [15:0] pc_val_d = boot_w ? `CMIC_RESET_PC : pif.vector; // RULE1 RULE20

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sys_reset_out       <= 1'b1;
      lcd_off_out         <= 1'b1;
      bias_on_out         <= 1'b1;
      cpu_run_out         <= 1'b0;
      halt_state_flag_out <= 1'b0;
    end else begin
      // Only CPU and SFR state follow this; RAM is left alone
      sys_reset_out       <= rst_d_w; // RULE8
      lcd_off_out         <= rst_d_w; // RULE9
      bias_on_out         <= rst_d_w; // RULE9
      cpu_run_out         <= run_d_w; // RULE2
      halt_state_flag_out <= halt_d_w; // RULE2 RULE11
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pc_load_out     <= 1'b0;
      pc_value_out    <= `CMIC_RESET_PC;
      push_pc_out     <= 1'b0;
      push_data_out   <= 16'h0000;
      irq_ack_out     <= '0;
      melody_xfer_out <= 1'b0;
    end else begin
      pc_load_out     <= pc_load_d; // RULE1 RULE25
      pc_value_out    <= pc_val_d;
      push_pc_out     <= take_w & !rst_src_w; // RULE25
      push_data_out   <= ret_pc_in; // RULE25
      irq_ack_out     <= (take_w & !rst_src_w) ? pif.sel : '0; // RULE22
      melody_xfer_out <= (mel_clr_w & !rst_src_w); // RULE17
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_mel_step;
    (st_q == cmic_pkg::CMIC_ST_MEL) && instr_done_in && !rst_src_w;
  endsequence
  sequence s_mel_back;
    ##1 (st_q == cmic_pkg::CMIC_ST_MXFER) ##1 melody_xfer_out && (st_q == cmic_pkg::CMIC_ST_HALT);
  endsequence

  a_boot_vector: assert property ($fell(sys_reset_out) |-> pc_load_out && pc_value_out == `CMIC_RESET_PC) // RULE1
    else $error("reset exit without load of start address");
  a_halt_frozen: assert property (halt_state_flag_out && st_q == cmic_pkg::CMIC_ST_HALT |-> !cpu_run_out) // RULE2
    else $error("cpu runs during halt");
  a_pin_sample: assert property (p2k_tick_w && pin_s_w |=> ##1 sys_reset_out) // RULE3
    else $error("sampled reset pin did not reset");
  a_key_second: assert property (key_tick_w && key_match_w && key_cnt_q == `CMIC_KEY_CNT_ONE |=> ##1 sys_reset_out) // RULE7
    else $error("key reset missed at second edge");
  a_reset_lcd: assert property (sys_reset_out |-> lcd_off_out && bias_on_out) // RULE9
    else $error("lcd drivers not off during reset");
  a_reset_abort: assert property (rst_src_w |=> st_q == cmic_pkg::CMIC_ST_RESET && !cpu_run_out) // RULE10
    else $error("reset did not abort execution");
  a_halt_nop: assert property (st_q == cmic_pkg::CMIC_ST_RUN && halt_instr_in && pif.accept |=> !halt_state_flag_out) // RULE13
    else $error("halt taken with interrupt pending");
  a_halt_hold: assert property (st_q == cmic_pkg::CMIC_ST_HALT && !pif.wake && !mel_pend_q && !rst_src_w
                                |=> halt_state_flag_out) // RULE15
    else $error("halt left without enabled request");
  a_take_entry: assert property (push_pc_out |-> pc_load_out && !master_irq_enable_out && $onehot(irq_ack_out)) // RULE23 RULE25
    else $error("interrupt entry incomplete");
  a_mel_rehalt: assert property (s_mel_step |-> s_mel_back) // RULE17
    else $error("melody step did not return to halt");
endmodule // cmic_ctrl

// file: cmic_ctrl_tb_top.sv
// Purpose: self-checking bench for the cpu mode and interrupt control block
// Assumes: short tick counts, inputs change 1 ns after the rising edge
// Notes:   bench owns the requests, the cpu model owns the strobes
`timescale 1ns/1ps
`include "cmic_defs.svh"
module cmic_ctrl_tb_top;
  localparam int         P2K  = 8;
  localparam int         P1HZ = 32;
  localparam logic [6:0] KEY_CASES [6] = '{7'h4B, 7'h44, 7'h57, 7'h1B, 7'h27, 7'h7F};
  logic                  mclk_in, rst_in, reset_pin_in, lfclk_stop_in, stop_det_opt_in;
  logic [3:0]            key_port_in;
  logic [1:0]            key_width_opt_in;
  logic                  halt_instr_in, instr_done_in, return_from_irq_instr_in, ei_in, di_in;
  logic                  melody_data_req_in;
  logic [`CMIC_NSRC-1:0] irq_req_in, irq_en_in, irq_ack_out, got_ack;
  logic [15:0]           ret_pc_in, pc_value_out, push_data_out, got_pc, got_push;
  logic                  sys_reset_out, lcd_off_out, bias_on_out, cpu_run_out, halt_state_flag_out;
  logic                  master_irq_enable_out, pc_load_out, push_pc_out, melody_xfer_out;
  logic                  halt_cmd, slow, got_master, hit;
  int                    miscompares, comparisons, seed, done_cnt, d0, n, i, k;
  cmic_ctrl #(.P2K_CYC(P2K), .P1HZ_CYC(P1HZ)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .reset_pin_in(reset_pin_in), .lfclk_stop_in(lfclk_stop_in),
    .stop_det_opt_in(stop_det_opt_in), .key_port_in(key_port_in), .key_width_opt_in(key_width_opt_in),
    .halt_instr_in(halt_instr_in), .instr_done_in(instr_done_in), .ei_in(ei_in),
    .return_from_irq_instr_in(return_from_irq_instr_in),
    .di_in(di_in), .melody_data_req_in(melody_data_req_in), .irq_req_in(irq_req_in), .irq_en_in(irq_en_in),
    .ret_pc_in(ret_pc_in), .sys_reset_out(sys_reset_out), .lcd_off_out(lcd_off_out), .bias_on_out(bias_on_out),
    .cpu_run_out(cpu_run_out), .halt_state_flag_out(halt_state_flag_out), .pc_load_out(pc_load_out),
    .master_irq_enable_out(master_irq_enable_out), .pc_value_out(pc_value_out), .push_pc_out(push_pc_out),
    .push_data_out(push_data_out), .irq_ack_out(irq_ack_out), .melody_xfer_out(melody_xfer_out));
  cmic_cpu_model u_cpu (.mclk_in(mclk_in), .rst_in(rst_in), .cpu_run_in(cpu_run_out), .pc_load_in(pc_load_out),
    .halt_cmd_in(halt_cmd), .slow_in(slow), .halt_instr_out(halt_instr_in), .instr_done_out(instr_done_in));
  // ****************************************
  // Clock, strobe count, helpers
  // ****************************************
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (instr_done_in === 1'b1) done_cnt <= done_cnt + 1;
  // Gaps at 001C and 002C are deliberate
  function automatic logic [15:0] vec_of(input int s);
    if (s <= 5) return 16'h0010 + 16'(2 * s);
    if (s <= 12) return 16'h001E + 16'(2 * (s - 6));
    return 16'h002E + 16'(2 * (s - 13));
  endfunction
  function automatic int pick(input logic [17:0] r, input logic [17:0] e);
    for (int s = 0; s < 18; s++) if (r[s] && (s == 0 || e[s])) return s;
    return -1;
  endfunction
  task chk_b(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task chk_v(input logic [17:0] got, input logic [17:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask
  task pulse_master(input logic use_ret);
    return_from_irq_instr_in = use_ret;
    ei_in = ~use_ret;
    cyc(1);
    chk_b(master_irq_enable_out, 1'b1, "master enable set");
    {return_from_irq_instr_in, ei_in} = 2'h0;
  endtask
  task mel_pulse;
    melody_data_req_in = 1'b1;
    cyc(1);
    melody_data_req_in = 1'b0;
    hit = 1'b0;
    for (n = 0; n < 20 && !hit; n++) begin
      cyc(1);
      hit = melody_xfer_out;
    end
  endtask
  task wait_ack(input int lim);
    hit = 1'b0;
    got_ack = '0;
    for (int t = 0; t < lim && !hit; t++) begin
      cyc(1);
      if (irq_ack_out !== '0) begin
        hit = 1'b1;
        got_ack = irq_ack_out;
        got_pc = pc_value_out;
        got_push = push_data_out;
        got_master = master_irq_enable_out;
        chk_b(pc_load_out & push_pc_out, 1'b1, "entry strobes");
        irq_req_in = irq_req_in & ~irq_ack_out;
      end
    end
  endtask
  task wait_rst(input logic lvl, input int lim);
    n = 0;
    while (sys_reset_out !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    chk_b(lcd_off_out & bias_on_out, sys_reset_out, "lcd follows reset");
  endtask
  // Halt is commanded right after a strobe so that r lands before S2
  task do_halt(input logic [17:0] r);
    n = 0;
    while (instr_done_in !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    cyc(1);
    halt_cmd = 1'b1;
    irq_req_in = r;
    cyc(1);
    halt_cmd = 1'b0;
  endtask
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #150us;
    miscompares++;
    wrap_up();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 5;
    rst_in = 1'b1;
    {reset_pin_in, lfclk_stop_in, stop_det_opt_in, halt_cmd, slow, ei_in, di_in, melody_data_req_in} = '0;
    return_from_irq_instr_in = 1'b0;
    key_port_in = 4'h5;
    key_width_opt_in = 2'h0;
    {irq_req_in, irq_en_in} = '0;
    ret_pc_in = 16'h0000;
    cyc(10);
    chk_b(lcd_off_out & bias_on_out & ~master_irq_enable_out, 1'b1, "reset outputs");
    rst_in = 1'b0;
    cyc(1);
    chk_b(pc_load_out & ~sys_reset_out & cpu_run_out, 1'b1, "reset exit");
    chk_v({2'h0, pc_value_out}, 18'h00000, "start address");
    irq_en_in = '1;
    for (i = 0; i < `CMIC_NSRC; i++) begin
      pulse_master(i[0]);
      ret_pc_in = 16'($random(seed));
      irq_req_in[i] = 1'b1;
      wait_ack(30);
      chk_v(got_ack, 18'h00001 << i, "ack");
      chk_v({2'h0, got_pc}, {2'h0, vec_of(i)}, "vector");
      chk_v({2'h0, got_push}, {2'h0, ret_pc_in}, "push");
      chk_b(got_master, 1'b0, "master enable after accept");
    end
    pulse_master(1'b0);
    di_in = 1'b1;
    cyc(1);
    di_in = 1'b0;
    irq_req_in = 18'h00008;
    wait_ack(20);
    chk_b(hit, 1'b0, "masked by master enable");
    irq_req_in[0] = 1'b1;
    wait_ack(20);
    chk_v(got_ack, 18'h00001, "watchdog unmasked");
    irq_en_in = 18'h3FFF7;
    pulse_master(1'b0);
    wait_ack(20);
    chk_b(hit, 1'b0, "masked by enable");
    irq_en_in = '1;
    wait_ack(20);
    chk_v(got_ack, 18'h00008, "held request");
    for (i = 0; i < 24; i++) begin
      slow = i[0];
      pulse_master(1'b0);
      irq_en_in = (i < 2) ? {i[0], 17'h1FFFF} & 18'h3FFFF : 18'($random(seed));
      irq_req_in = (i == 0) ? 18'h3FFFF : (i == 1) ? 18'h3FFFE : 18'($random(seed));
      k = pick(irq_req_in, irq_en_in);
      wait_ack(30);
      if (k < 0) chk_b(hit, 1'b0, "nothing enabled");
      else chk_v(got_ack, 18'h00001 << k, "priority");
      irq_req_in = '0;
    end
    slow = 1'b0;
    pulse_master(1'b0);
    do_halt(18'h00004);
    wait_ack(20);
    chk_v(got_ack, 18'h00004, "halt with request");
    chk_b(halt_state_flag_out | ~cpu_run_out, 1'b0, "halt skipped");
    irq_en_in = '0;
    do_halt('0);
    cyc(3);
    chk_b(halt_state_flag_out & ~cpu_run_out, 1'b1, "halt entered");
    d0 = done_cnt;
    irq_req_in = 18'h00080;
    cyc(20);
    chk_b(halt_state_flag_out, 1'b1, "wake without enable");
    chk_v(18'(done_cnt - d0), 18'h00000, "no progress in halt");
    irq_en_in = 18'h00280;
    cyc(3);
    chk_b(halt_state_flag_out | ~cpu_run_out, 1'b0, "wake with master low");
    wait_ack(20);
    chk_b(hit, 1'b0, "plain run");
    pulse_master(1'b1);
    wait_ack(20);
    chk_v(got_ack, 18'h00080, "late accept");
    pulse_master(1'b0);
    do_halt('0);
    cyc(3);
    irq_req_in = 18'h00200;
    d0 = done_cnt;
    wait_ack(20);
    chk_v(got_ack, 18'h00200, "wake vector");
    chk_v(18'(done_cnt - d0), 18'h00001, "one instruction first");
    pulse_master(1'b0);
    do_halt('0);
    cyc(3);
    d0 = done_cnt;
    mel_pulse();
    chk_b(hit & halt_state_flag_out, 1'b1, "melody transfer");
    chk_v(18'(done_cnt - d0), 18'h00001, "melody step");
    cyc(2);
    chk_b(halt_state_flag_out & ~cpu_run_out, 1'b1, "halt again");
    reset_pin_in = 1'b1;
    wait_rst(1'b1, 3 * P2K);
    chk_b(sys_reset_out, 1'b1, "pin reset");
    chk_b(halt_state_flag_out | cpu_run_out | master_irq_enable_out, 1'b0, "cpu init");
    reset_pin_in = 1'b0;
    wait_rst(1'b0, 3 * P2K);
    chk_b(pc_load_out, 1'b1, "restart");
    mel_pulse();
    chk_b(hit & cpu_run_out & ~halt_state_flag_out, 1'b1, "melody in run");
    for (i = 0; i < 6; i++) begin
      key_width_opt_in = KEY_CASES[i][5:4];
      cyc(3 * P1HZ);
      key_port_in = KEY_CASES[i][3:0];
      wait_rst(1'b1, 3 * P1HZ);
      chk_b(sys_reset_out, KEY_CASES[i][6], "key reset");
      if (KEY_CASES[i][6]) chk_b(n >= P1HZ && n <= 2 * P1HZ + 6, 1'b1, "key timing");
      key_port_in = 4'h5;
      wait_rst(1'b0, 3 * P1HZ);
    end
    lfclk_stop_in = 1'b1;
    wait_rst(1'b1, 20);
    chk_b(sys_reset_out, 1'b0, "stop option off");
    stop_det_opt_in = 1'b1;
    wait_rst(1'b1, 8);
    chk_b(sys_reset_out, 1'b1, "clock stop reset");
    lfclk_stop_in = 1'b0;
    wait_rst(1'b0, 8);
    chk_b(pc_load_out, 1'b1, "restart after stop");
    wrap_up();
  end
endmodule // cmic_ctrl_tb_top

// file: cmic_defs.svh
// Purpose: constants for the cpu mode and interrupt control block
// Assumes: 200 MHz mclk_in
// Notes:   one header shared by the ctrl, prio, interface and bench files; pkg and cpu model do not include it
// Function
// RULE1: After reset processing ends, fetch starts at program address 0000H.
// RULE2: Halt freezes the program counter and execution; peripherals keep running.
// RULE3: Reset pin sampled at 2 kHz; high sample resets; driver holds 1 ms.
// RULE4: Optional low-frequency clock stop detection forces system reset.
// RULE5: Port 0 key press sampled at 1 Hz resets; keys held 2-3 s.
// RULE6: Option picks key width: low 2, low 3 or all 4 bits.
// RULE7: Matching keys reset at the second falling edge of 1 Hz.
// RULE8: Reset initialises CPU and SFRs, leaves data RAM and LCD segments.
// RULE9: During reset LCD drivers off at ground, bias reference energised.
// RULE10: Reset overrides every state and aborts execution at once.
// RULE11: Halt instruction enters halt mode at its S2 state.
// RULE12: Oscillator and time base keep running during halt.
// RULE13: Halt with a pending interrupt acts as no-op; interrupt is serviced.
// RULE14: Interrupt wake runs one instruction after halt, then vectors.
// RULE15: Only individually enabled requests clear the halt flag; master enable ignored.
// RULE16: Reset pin, key reset or clock stop release halt into reset.
// RULE17: Melody data request in halt: one instruction, transfer, halt again.
// RULE18: Eighteen sources: four external, fourteen internal.
// RULE19: All but watchdog gated by master and individual enables.
// RULE20: Each source vectors to fixed even address 0010H to 0036H.
// RULE21: Timers at 0020H-0026H, serial receive 0028H, transmit 002AH.
// RULE22: Simultaneous requests: lowest start address first, others held.
// RULE23: Accepting clears master enable; return from interrupt sets it; resets zero.
// RULE24: Maskable request reaches CPU only if request AND enable.
// RULE25: Accept saves return PC on call stack and loads start address.
`ifndef CMIC_DEFS_SVH
`define CMIC_DEFS_SVH
`define CMIC_CLK_HZ        200000000
`define CMIC_PIN_SMP_HZ    2000
`define CMIC_KEY_SMP_HZ    1
`define CMIC_RST_MIN_US    1000
`define CMIC_RST_MIN_CYC   (`CMIC_CLK_HZ / 1000000 * `CMIC_RST_MIN_US)
`define CMIC_NSRC          18
`define CMIC_SRC_WDT       0
`define CMIC_RESET_PC      16'h0000
`define CMIC_KEY_W2        2'h0
`define CMIC_KEY_W3        2'h1
`define CMIC_KEY_MASK2     4'h3
`define CMIC_KEY_MASK3     4'h7
`define CMIC_KEY_MASK4     4'hF
`define CMIC_KEY_NONE      4'h0
`define CMIC_KEY_CNT_HIT   2'h2
`define CMIC_KEY_CNT_ONE   2'h1
`define CMIC_VEC_TABLE { \
  16'h0036, 16'h0034, 16'h0032, 16'h0030, 16'h002E, 16'h002A, \
  16'h0028, 16'h0026, 16'h0024, 16'h0022, 16'h0020, 16'h001E, \
  16'h001A, 16'h0018, 16'h0016, 16'h0014, 16'h0012, 16'h0010 }
`endif

// file: cmic_if.sv
// Purpose: carrier between the controller and its priority encoder
// Assumes: one clock domain, purely combinational content
// Notes:   ctl drives requests and enables, enc answers with selection
`timescale 1ns/1ps
`include "cmic_defs.svh"
interface cmic_if;
  logic [`CMIC_NSRC-1:0] req;
  logic [`CMIC_NSRC-1:0] en;
  logic                  master_irq_enable;
  logic                  accept;
  logic                  wake;
  logic [`CMIC_NSRC-1:0] sel;
  logic [15:0]           vector;
  modport ctl (output req, en, master_irq_enable, input accept, wake, sel, vector);
  modport enc (input req, en, master_irq_enable, output accept, wake, sel, vector);
endinterface // cmic_if

// file: cmic_pkg.sv
// Purpose: types of the cpu mode and interrupt control block
// Assumes: nothing
// Notes:   operating states of the sequencing machine
package cmic_pkg;
  typedef enum logic [2:0] {
    CMIC_ST_RESET = 3'h0,
    CMIC_ST_RUN   = 3'h1,
    CMIC_ST_HALT  = 3'h2,
    CMIC_ST_WAKE  = 3'h3,
    CMIC_ST_MEL   = 3'h4,
    CMIC_ST_MXFER = 3'h5
  } cmic_state_t;
endpackage

// file: cmic_prio.sv
// Purpose: masks, priority selection and vector lookup of 18 sources
// Assumes: index 0 is the watchdog, index order equals priority order
// Notes:   combinational; the controller registers what it uses
`timescale 1ns/1ps
`include "cmic_defs.svh"
module cmic_prio (
  cmic_if.enc bus
);
  localparam logic [`CMIC_NSRC*16-1:0] VEC_TBL = `CMIC_VEC_TABLE;

  wire [`CMIC_NSRC-1:0] acc_w;
  wire [`CMIC_NSRC-1:0] wake_w;
  wire [`CMIC_NSRC:0]   blk_w;
  wire [15:0]           vpart_w [0:`CMIC_NSRC];

  assign blk_w[0]   = 1'b0;
  assign vpart_w[0] = 16'h0000;

  genvar i;
  generate
    for (i = 0; i < `CMIC_NSRC; i = i + 1) begin : g_src
      if (i == `CMIC_SRC_WDT) begin : g_nmi
        // Watchdog is never masked
        assign acc_w[i]  = bus.req[i]; // RULE19
        assign wake_w[i] = bus.req[i];
      end else begin : g_mask
        assign acc_w[i]  = bus.req[i] & bus.en[i] & bus.master_irq_enable; // RULE19 RULE24
        // Halt release ignores the master enable
        assign wake_w[i] = bus.req[i] & bus.en[i]; // RULE15
      end
      assign bus.sel[i]   = acc_w[i] & ~blk_w[i]; // RULE22
      assign blk_w[i+1]   = blk_w[i] | acc_w[i];
      assign vpart_w[i+1] = vpart_w[i] | ({16{bus.sel[i]}} & VEC_TBL[i*16 +: 16]); // RULE20 RULE21
    end
  endgenerate

  assign bus.accept = blk_w[`CMIC_NSRC];
  assign bus.wake   = |wake_w;
  assign bus.vector = vpart_w[`CMIC_NSRC];
endmodule // cmic_prio
